// ===== core/lin_flags_map.svh
// Register offsets, field positions, reset values and counts
`ifndef LIN_FLAGS_MAP_SVH
`define LIN_FLAGS_MAP_SVH

`define OFS_STATUS 8'h00
`define OFS_ERROR 8'h04
`define OFS_IRQ_EN 8'h08
`define OFS_CTRL_ONE 8'h0c
`define OFS_TIMEOUT_CTRL 8'h10
`define OFS_COMPARE 8'h14

`define ST_HEADER 0
`define ST_TX_DONE 1
`define ST_RX_DONE 2
`define ST_EMPTY 3
`define ST_FULL 4
`define ST_WAKE 5
`define ST_W 6

`define ER_NOISE 0
`define ER_RSVD 1
`define ER_OVERRUN 2
`define ER_FRAMING 3
`define ER_ID_PARITY 4
`define ER_BREAK_DELIM 5
`define ER_SYNC 6
`define ER_CHECKSUM 7
`define ER_BIT 8
`define ER_COMPARE 9
`define ER_STUCK 10
`define ER_W 11

`define IE_HEADER_ERR 0
`define IE_WAKE 1

`define CR_DFL_W 6
`define CR_BYPASS 6
`define CR_CCD 7
`define CR_CFD 8
`define CR_RX_BUFFER_LOCK 9
`define CR_IDLE_ON_BIT_ERROR 10
`define CR_W 11

`define TC_IDLE_ON_TIMEOUT 0
`define TC_TIMEOUT_MODE 1

`define EXT_DFL_MIN 6'h07
`define STUCK_BITS 7'h64
`define CTRL_RESET 11'h000
`define COMPARE_RESET 16'h0000

`endif

// ===== core/lin_flags_pkg.sv
// Shared types of the LIN status and error flag block
package lin_flags_pkg;
  typedef logic [7:0] byte_t;
  typedef logic [31:0] word_t;
  typedef logic [7:0] addr_t;
  typedef enum {SEL_STATUS, SEL_ERROR, SEL_IRQ_EN, SEL_CTRL_ONE,
                SEL_TIMEOUT_CTRL, SEL_COMPARE, SEL_NONE} reg_sel_t;
endpackage

// ===== core/lin_status_error_flags.sv
// LIN controller status and error flags with their register port
`timescale 1ns/1ps
`include "lin_flags_map.svh"

module lin_status_error_flags (
  input wire logic CLOCK_I, // 100 MHz clock
  input wire logic NRST_I, // Sync reset, active low
  input wire logic [7:0] ADDR_I, // Register byte address
  input wire logic [31:0] WR_DATA_I, // Write data
  input wire logic WR_EN_I, // Write strobe
  input wire logic RD_EN_I, // Read strobe
  output logic [31:0] RD_DATA_O, // Read data, cycle after strobe
  input wire logic INIT_MODE_I, // Controller in init mode
  input wire logic MASTER_I, // High as master, low as slave
  input wire logic SLEEP_I, // Controller in sleep mode
  input wire logic IDLE_I, // Controller in idle state
  input wire logic RX_LINE_I, // Bus receive level
  input wire logic BIT_TICK_I, // One pulse per bit time
  input wire logic FRAME_END_I, // Frame completed or aborted
  input wire logic RX_BYTE_VALID_I, // Received byte strobe
  input wire logic [7:0] RX_BYTE_I, // Received byte
  input wire logic BUF_FILLED_I, // Receive buffer became full
  input wire logic BUF_EMPTIED_I, // Transmit buffer became empty
  input wire logic RX_DONE_I, // Data reception finished
  input wire logic TX_DONE_I, // Data transmission finished
  input wire logic HDR_VALID_I, // Valid header received
  input wire logic FILTER_EN_I, // Identifier filters enabled
  input wire logic FILTER_ACTIVE_I, // Any filter active
  input wire logic FILTER_MATCH_I, // Some filter matched
  input wire logic TX_FILTER_MATCH_I, // Transmit filter matched
  input wire logic TIMEOUT_RUN_I, // Timeout counter running
  input wire logic [7:0] TIMEOUT_CNT_I, // Timeout counter value
  input wire logic TX_HEADER_I, // Header transmission phase
  input wire logic TX_RESPONSE_I, // Response transmission phase
  input wire logic TX_LEVEL_I, // Level being transmitted
  input wire logic BIT_SAMPLE_I, // Read-back sample strobe
  input wire logic CHK_VALID_I, // Checksum field received
  input wire logic [7:0] RX_CHK_I, // Received checksum
  input wire logic [7:0] CALC_CHK_I, // Computed checksum
  input wire logic SYNC_BAD_I, // Inconsistent sync field
  input wire logic DELIM_SHORT_I, // Break delimiter too short
  input wire logic ID_VALID_I, // Identifier field received
  input wire logic [7:0] RX_ID_I, // Received identifier
  input wire logic STOP_SAMPLE_I, // Stop bit sample strobe
  input wire logic RX_HEADER_I, // Receiving sync or identifier
  input wire logic RX_RESPONSE_I, // Receiving response data
  input wire logic NOISE_I, // Noise seen on a character
  output logic WAKE_IRQ_O, // Wake interrupt
  output logic HEADER_IRQ_O, // Header error interrupt
  output logic GO_IDLE_O, // Request move to idle
  output logic TX_HOLD_O, // Hold transmission, refill
  output logic [7:0] RX_BUF_O // Receive buffer byte
);

  logic [`ST_W-1:0] status;
  logic [`ER_W-1:0] errors;
  logic [1:0] irq_en;
  logic [`CR_W-1:0] ctrl_one;
  logic [1:0] timeout_ctrl;
  logic [15:0] compare;
  lin_flags_pkg::byte_t rx_buf;
  logic rx_prev;
  logic [6:0] stuck_cnt;
  logic frame_bit_err;
  logic frame_stop_err;
  lin_flags_pkg::reg_sel_t wr_sel;
  lin_flags_pkg::reg_sel_t rd_sel;
  logic [`ST_W-1:0] st_clr;
  logic [`ER_W-1:0] er_clr;
  logic [`ST_W-1:0] st_set;
  logic [`ER_W-1:0] er_set;
  logic [`ST_W-1:0] next_status;
  logic [`ER_W-1:0] next_errors;
  logic [`ST_W-1:0] st_init;
  logic [`ER_W-1:0] er_init;
  logic dominant;
  logic rx_fall;
  logic wake_cond;
  logic extended;
  logic bit_err_ev;
  logic stop_err_ev;
  logic hdr_set;
  logic cmp_hit;
  logic stuck_ev;
  logic wake_flag;
  logic buffer_full_flag;
  logic buffer_empty_flag;
  logic header_rx_flag;
  logic compare_match_flag;
  logic filter_bypass;
  logic rx_buffer_lock;
  logic idle_on_bit_error;

  function automatic lin_flags_pkg::reg_sel_t decode(
      input lin_flags_pkg::addr_t a);
    case (a)
      `OFS_STATUS: decode = lin_flags_pkg::SEL_STATUS;
      `OFS_ERROR: decode = lin_flags_pkg::SEL_ERROR;
      `OFS_IRQ_EN: decode = lin_flags_pkg::SEL_IRQ_EN;
      `OFS_CTRL_ONE: decode = lin_flags_pkg::SEL_CTRL_ONE;
      `OFS_TIMEOUT_CTRL: decode = lin_flags_pkg::SEL_TIMEOUT_CTRL;
      `OFS_COMPARE: decode = lin_flags_pkg::SEL_COMPARE;
      default: decode = lin_flags_pkg::SEL_NONE;
    endcase
  endfunction

  // Parity bits are identifier bits 6 and 7
  function automatic logic id_parity_ok(input lin_flags_pkg::byte_t id);
    logic p0;
    logic p1;
    p0 = id[0] ^ id[1] ^ id[2] ^ id[4];
    p1 = ~(id[1] ^ id[3] ^ id[4] ^ id[5]);
    id_parity_ok = (id[6] == p0) && (id[7] == p1);
  endfunction

  assign wr_sel = WR_EN_I ? decode(ADDR_I) : lin_flags_pkg::SEL_NONE;
  assign rd_sel = RD_EN_I ? decode(ADDR_I) : lin_flags_pkg::SEL_NONE;

  assign wake_flag = status[`ST_WAKE];
  assign buffer_full_flag = status[`ST_FULL];
  assign buffer_empty_flag = status[`ST_EMPTY];
  assign header_rx_flag = status[`ST_HEADER];
  assign compare_match_flag = errors[`ER_COMPARE];
  assign filter_bypass = ctrl_one[`CR_BYPASS];
  assign rx_buffer_lock = ctrl_one[`CR_RX_BUFFER_LOCK];
  assign idle_on_bit_error = ctrl_one[`CR_IDLE_ON_BIT_ERROR];
  assign dominant = ~RX_LINE_I;
  assign extended = ctrl_one[`CR_DFL_W-1:0] > `EXT_DFL_MIN;

  assign st_clr = (wr_sel == lin_flags_pkg::SEL_STATUS) ?
                  WR_DATA_I[`ST_W-1:0] : '0;
  assign er_clr = (wr_sel == lin_flags_pkg::SEL_ERROR) ?
                  WR_DATA_I[`ER_W-1:0] : '0;

  assign rx_fall = rx_prev & ~RX_LINE_I;
  assign wake_cond = MASTER_I ? (SLEEP_I | IDLE_I) : SLEEP_I;

  assign bit_err_ev = BIT_SAMPLE_I & (RX_LINE_I != TX_LEVEL_I) &
                      (TX_RESPONSE_I | (TX_HEADER_I & MASTER_I));

  assign stop_err_ev = STOP_SAMPLE_I & dominant &
                       (RX_RESPONSE_I | (RX_HEADER_I & ~MASTER_I));

  assign hdr_set = HDR_VALID_I & (~FILTER_EN_I |
                   (filter_bypass & ~FILTER_ACTIVE_I) |
                   (filter_bypass & ~FILTER_MATCH_I) |
                   TX_FILTER_MATCH_I);

  assign cmp_hit = TIMEOUT_RUN_I &
                   ((TIMEOUT_CNT_I == compare[7:0]) |
                    (TIMEOUT_CNT_I == compare[15:8]));

  assign stuck_ev = BIT_TICK_I & dominant & (stuck_cnt == `STUCK_BITS);

  always_comb begin
    st_set = '0;
    st_set[`ST_WAKE] = rx_fall & wake_cond;
    st_set[`ST_FULL] = BUF_FILLED_I & extended;
    st_set[`ST_EMPTY] = BUF_EMPTIED_I & extended;
    st_set[`ST_RX_DONE] = RX_DONE_I & ~frame_bit_err & ~frame_stop_err &
                          ~bit_err_ev & ~stop_err_ev;
    st_set[`ST_TX_DONE] = TX_DONE_I &
                          (idle_on_bit_error | (~frame_bit_err & ~bit_err_ev));
    st_set[`ST_HEADER] = hdr_set;
  end

  always_comb begin
    er_set = '0;
    er_set[`ER_STUCK] = stuck_ev;
    er_set[`ER_COMPARE] = cmp_hit;
    er_set[`ER_BIT] = bit_err_ev;
    er_set[`ER_CHECKSUM] = CHK_VALID_I & (RX_CHK_I != CALC_CHK_I) &
                           ~ctrl_one[`CR_CCD] & ~ctrl_one[`CR_CFD];
    er_set[`ER_SYNC] = SYNC_BAD_I;
    er_set[`ER_BREAK_DELIM] = DELIM_SHORT_I;
    er_set[`ER_ID_PARITY] = ID_VALID_I & ~id_parity_ok(RX_ID_I);
    er_set[`ER_FRAMING] = stop_err_ev;
    er_set[`ER_OVERRUN] = RX_BYTE_VALID_I & buffer_full_flag;
    er_set[`ER_NOISE] = NOISE_I;
  end

  // Init wipes the status group; errors survive init, except the compare flag when timeout mode is set
  always_comb begin
    st_init = {`ST_W{INIT_MODE_I}};
    er_init = '0;
    er_init[`ER_COMPARE] = INIT_MODE_I & timeout_ctrl[`TC_TIMEOUT_MODE];
  end

  always_comb begin
    next_status = ~st_init & (st_set | (status & ~st_clr));
    next_errors = ~er_init & (er_set | (errors & ~er_clr));
    if (FRAME_END_I && !hdr_set) begin
      next_status[`ST_HEADER] = 1'b0;
    end
    next_errors[`ER_RSVD] = 1'b0;
  end

  always_ff @(posedge CLOCK_I) begin
    if (!NRST_I) begin
      status <= '0;
      errors <= '0;
    end else begin
      status <= next_status;
      errors <= next_errors;
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (!NRST_I) begin
      irq_en <= 2'h0;
      ctrl_one <= `CTRL_RESET;
      timeout_ctrl <= 2'h0;
      compare <= `COMPARE_RESET;
    end else begin
      if (wr_sel == lin_flags_pkg::SEL_IRQ_EN) begin
        irq_en <= WR_DATA_I[1:0];
      end
      if (wr_sel == lin_flags_pkg::SEL_CTRL_ONE) begin
        ctrl_one <= WR_DATA_I[`CR_W-1:0];
      end
      if (wr_sel == lin_flags_pkg::SEL_TIMEOUT_CTRL) begin
        timeout_ctrl <= WR_DATA_I[1:0];
      end
      if (wr_sel == lin_flags_pkg::SEL_COMPARE) begin
        compare <= WR_DATA_I[15:0];
      end
    end
  end

  // Read data lives one cycle only, zero otherwise
  always_ff @(posedge CLOCK_I) begin
    if (!NRST_I) begin
      RD_DATA_O <= 32'h0;
    end else begin
      case (rd_sel)
        lin_flags_pkg::SEL_STATUS: RD_DATA_O <= {26'h0, status};
        lin_flags_pkg::SEL_ERROR: RD_DATA_O <= {21'h0, errors};
        lin_flags_pkg::SEL_IRQ_EN: RD_DATA_O <= {30'h0, irq_en};
        lin_flags_pkg::SEL_CTRL_ONE: RD_DATA_O <= {21'h0, ctrl_one};
        lin_flags_pkg::SEL_TIMEOUT_CTRL: RD_DATA_O <= {30'h0, timeout_ctrl};
        lin_flags_pkg::SEL_COMPARE: RD_DATA_O <= {16'h0, compare};
        default: RD_DATA_O <= 32'h0;
      endcase
    end
  end

  // Idle line is recessive, so edge history starts high
  always_ff @(posedge CLOCK_I) begin
    if (!NRST_I) begin
      rx_prev <= 1'b1;
    end else begin
      rx_prev <= RX_LINE_I;
    end
  end

  // Saturates above the limit so one long low sets once
  always_ff @(posedge CLOCK_I) begin
    if (!NRST_I) begin
      stuck_cnt <= 7'h00;
    end else if (!dominant) begin
      stuck_cnt <= 7'h00;
    end else if (BIT_TICK_I && stuck_cnt <= `STUCK_BITS) begin
      stuck_cnt <= stuck_cnt + 7'h01;
    end
  end

  // Per-frame error memory; a new error beats the frame end
  always_ff @(posedge CLOCK_I) begin
    if (!NRST_I || INIT_MODE_I) begin
      frame_bit_err <= 1'b0;
      frame_stop_err <= 1'b0;
    end else begin
      frame_bit_err <= bit_err_ev | (frame_bit_err & ~FRAME_END_I);
      frame_stop_err <= stop_err_ev | (frame_stop_err & ~FRAME_END_I);
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (!NRST_I) begin
      rx_buf <= 8'h00;
    end else if (RX_BYTE_VALID_I && !(buffer_full_flag && rx_buffer_lock)) begin
      rx_buf <= RX_BYTE_I;
    end
  end

  assign RX_BUF_O = rx_buf;
  assign WAKE_IRQ_O = wake_flag & irq_en[`IE_WAKE];
  assign HEADER_IRQ_O = irq_en[`IE_HEADER_ERR] & (errors[`ER_SYNC] |
                        errors[`ER_BREAK_DELIM] | errors[`ER_ID_PARITY]);
  assign GO_IDLE_O = compare_match_flag & timeout_ctrl[`TC_IDLE_ON_TIMEOUT];
  assign TX_HOLD_O = buffer_empty_flag;

  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (!NRST_I);

  AST_WAKE_SET: assert property (
    rx_fall && wake_cond && !INIT_MODE_I |=> wake_flag)
    else $error("wake flag not set");
  AST_WAKE_IRQ: assert property (
    $rose(wake_flag) && irq_en[`IE_WAKE] |-> WAKE_IRQ_O)
    else $error("wake interrupt missing");
  AST_FULL_SHORT: assert property (
    !buffer_full_flag && !extended |=> !buffer_full_flag)
    else $error("buffer full set on short frame");
  AST_HOLD: assert property (
    BUF_EMPTIED_I && extended && !INIT_MODE_I |=> TX_HOLD_O)
    else $error("transmit not held");
  AST_RX_DONE_BLOCK: assert property (
    !status[`ST_RX_DONE] && (frame_stop_err || stop_err_ev)
    |=> !status[`ST_RX_DONE])
    else $error("rx done set after framing error");
  AST_TX_DONE_BLOCK: assert property (
    !status[`ST_TX_DONE] && frame_bit_err && !idle_on_bit_error
    |=> !status[`ST_TX_DONE])
    else $error("tx done set after bit error");
  AST_HDR_END: assert property (
    FRAME_END_I && !HDR_VALID_I |=> !header_rx_flag)
    else $error("header flag kept past frame end");
  AST_STUCK: assert property (
    stuck_ev |=> errors[`ER_STUCK])
    else $error("stuck low not flagged");
  AST_IDLE: assert property (
    cmp_hit && timeout_ctrl[`TC_IDLE_ON_TIMEOUT] && !INIT_MODE_I
    |=> GO_IDLE_O)
    else $error("no idle request on compare");
  AST_OCF_KEEP: assert property (
    compare_match_flag && !timeout_ctrl[`TC_TIMEOUT_MODE] &&
    !er_clr[`ER_COMPARE] |=> compare_match_flag)
    else $error("compare flag lost");
  AST_CHK_OFF: assert property (
    !errors[`ER_CHECKSUM] && ctrl_one[`CR_CCD] |=> !errors[`ER_CHECKSUM])
    else $error("checksum error while disabled");
  AST_HDR_IRQ: assert property (
    $rose(errors[`ER_SYNC]) && irq_en[`IE_HEADER_ERR] |-> HEADER_IRQ_O)
    else $error("header interrupt missing");
  AST_OVR_LOCK: assert property (
    RX_BYTE_VALID_I && buffer_full_flag && rx_buffer_lock
    |=> $stable(RX_BUF_O) && errors[`ER_OVERRUN])
    else $error("locked buffer overwritten");
  AST_RSVD: assert property (
    rd_sel == lin_flags_pkg::SEL_ERROR |=> RD_DATA_O[`ER_RSVD] == 1'b0)
    else $error("reserved bit not zero");
  AST_SET_WINS: assert property (
    NOISE_I && er_clr[`ER_NOISE] |=> errors[`ER_NOISE])
    else $error("clear beat hardware set");

  COV_WAKE: cover property (rx_fall && wake_cond ##1 WAKE_IRQ_O);
  COV_OVERRUN: cover property (RX_BYTE_VALID_I && buffer_full_flag);
  COV_STUCK: cover property (stuck_ev);
  COV_HDR_IRQ: cover property ($rose(HEADER_IRQ_O));

endmodule

// ===== verification/lin_far_node.sv
// Far-side bus node: dominant hold and bit timing
`timescale 1ns/1ps
module lin_far_node (
  input wire logic clock_i, // Controller clock
  input wire logic nrst_i, // Sync reset, active low
  input wire logic hold_low_i, // Pull the bus dominant
  input wire logic tx_level_i, // Level our controller sends
  output logic rx_line_o, // Resolved bus level
  output logic bit_tick_o // One pulse per bit time
);
  logic [2:0] phase;
  // Pulled-up wired-AND bus, so either node can force it low
  assign rx_line_o = tx_level_i & ~hold_low_i;
  // Short bit time keeps the 100-bit stuck check quick
  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      phase <= 3'h0;
      bit_tick_o <= 1'b0;
    end else begin
      phase <= phase + 3'h1;
      bit_tick_o <= (phase == 3'h7);
    end
  end
endmodule

// ===== verification/test_lin_status_error_flags.sv
// Self-checking bench of the LIN status and error flag block
`timescale 1ns/1ps
`include "lin_flags_map.svh"
module test_lin_status_error_flags;
  localparam int FE = 0, BYT = 1, FUL = 2, EMP = 3, RXD = 4, TXD = 5;
  localparam int HDR = 6, BS = 7, CHK = 8, SYN = 9, DLM = 10, IDV = 11;
  localparam int STP = 12, NOI = 13;
  logic clk = 1'b0, nrst = 1'b0, wr_en = 1'b0, rd_en = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [13:0] ev = 14'h0;
  logic init = 1'b0, master = 1'b0, sleep = 1'b0, idle = 1'b0;
  logic hold = 1'b0, f_en = 1'b0, f_act = 1'b0, f_mat = 1'b0;
  logic f_tx = 1'b0, t_run = 1'b0, tx_rsp = 1'b0, rx_rsp = 1'b0;
  logic tx_hdr = 1'b0, rx_hdr = 1'b0, tx_lvl = 1'b1;
  logic [7:0] rx_byte = 8'h0, t_cnt = 8'h0, rx_chk = 8'h0;
  logic [7:0] calc_chk = 8'h0, rx_id = 8'h0;
  logic [31:0] rd_data;
  logic [7:0] rx_buf;
  logic wake_irq, hdr_irq, go_idle, tx_hold, rx_line, tick;
  int bad_count = 0;
  int tests_run = 0;
  always #5 clk = ~clk;
  lin_status_error_flags lin_status_error_flags_inst (
    .CLOCK_I(clk), .NRST_I(nrst), .ADDR_I(addr), .WR_DATA_I(wdata),
    .WR_EN_I(wr_en), .RD_EN_I(rd_en), .RD_DATA_O(rd_data),
    .INIT_MODE_I(init), .MASTER_I(master), .SLEEP_I(sleep),
    .IDLE_I(idle), .RX_LINE_I(rx_line), .BIT_TICK_I(tick),
    .FRAME_END_I(ev[FE]), .RX_BYTE_VALID_I(ev[BYT]), .RX_BYTE_I(rx_byte),
    .BUF_FILLED_I(ev[FUL]), .BUF_EMPTIED_I(ev[EMP]), .RX_DONE_I(ev[RXD]),
    .TX_DONE_I(ev[TXD]), .HDR_VALID_I(ev[HDR]), .FILTER_EN_I(f_en),
    .FILTER_ACTIVE_I(f_act), .FILTER_MATCH_I(f_mat),
    .TX_FILTER_MATCH_I(f_tx), .TIMEOUT_RUN_I(t_run), .TIMEOUT_CNT_I(t_cnt),
    .TX_HEADER_I(tx_hdr), .TX_RESPONSE_I(tx_rsp), .TX_LEVEL_I(tx_lvl),
    .BIT_SAMPLE_I(ev[BS]), .CHK_VALID_I(ev[CHK]), .RX_CHK_I(rx_chk),
    .CALC_CHK_I(calc_chk), .SYNC_BAD_I(ev[SYN]), .DELIM_SHORT_I(ev[DLM]),
    .ID_VALID_I(ev[IDV]), .RX_ID_I(rx_id), .STOP_SAMPLE_I(ev[STP]),
    .RX_HEADER_I(rx_hdr), .RX_RESPONSE_I(rx_rsp), .NOISE_I(ev[NOI]),
    .WAKE_IRQ_O(wake_irq), .HEADER_IRQ_O(hdr_irq), .GO_IDLE_O(go_idle),
    .TX_HOLD_O(tx_hold), .RX_BUF_O(rx_buf));
  lin_far_node lin_far_node_inst (.clock_i(clk), .nrst_i(nrst),
    .hold_low_i(hold), .tx_level_i(tx_lvl), .rx_line_o(rx_line),
    .bit_tick_o(tick));
  task automatic chk(input string n, input logic [31:0] e, g);
    tests_run++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr_en <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask
  task automatic rdc(input string n, input logic [7:0] a,
                     input logic [31:0] e);
    @(posedge clk);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd_en <= 1'b0;
    // Data stands only in this cycle; taken at its closing edge
    @(posedge clk);
    chk(n, e, rd_data);
  endtask
  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge clk);
      while (!tick) @(posedge clk);
    end
  endtask
  task automatic pulse(input int b);
    @(posedge clk);
    ev <= 14'h1 << b;
    @(posedge clk);
    ev <= 14'h0;
  endtask
  task automatic dip;
    hold <= 1'b1;
    repeat (2) @(posedge clk);
    hold <= 1'b0;
  endtask
  task automatic init_pulse;
    @(posedge clk);
    init <= 1'b1;
    @(posedge clk);
    init <= 1'b0;
  endtask
  task automatic clr;
    wr(`OFS_STATUS, 32'hffffffff);
    wr(`OFS_ERROR, 32'hffffffff);
  endtask
  task automatic t_wake;
    dip;
    rdc("wake awake", `OFS_STATUS, 0); // slave
    sleep <= 1'b1;
    wr(`OFS_IRQ_EN, 1 << `IE_WAKE);
    dip;
    @(posedge clk);
    chk("wake irq", 1, 32'(wake_irq)); // irq
    wr(`OFS_STATUS, 0);
    rdc("wake kept", `OFS_STATUS, 1 << `ST_WAKE); // zero
    wr(`OFS_STATUS, 1 << `ST_WAKE);
    rdc("wake clr", `OFS_STATUS, 0); // clear
    sleep <= 1'b0;
    master <= 1'b1;
    idle <= 1'b1;
    dip;
    rdc("wake idle", `OFS_STATUS, 1 << `ST_WAKE); // master
    init_pulse;
    rdc("wake init", `OFS_STATUS, 0); // init
    master <= 1'b0;
    idle <= 1'b0;
  endtask
  task automatic t_buf;
    wr(`OFS_CTRL_ONE, 32'h7);
    pulse(FUL);
    pulse(EMP);
    rdc("short frame", `OFS_STATUS, 0); // length
    wr(`OFS_CTRL_ONE, 32'h8);
    pulse(FUL);
    rx_byte <= 8'ha5;
    pulse(BYT);
    @(posedge clk);
    chk("overwrite", 32'ha5, 32'(rx_buf)); // store
    rdc("overrun", `OFS_ERROR, 1 << `ER_OVERRUN); // flag
    wr(`OFS_CTRL_ONE, 32'h8 | (1 << `CR_RX_BUFFER_LOCK));
    rx_byte <= 8'h3c;
    pulse(BYT);
    @(posedge clk);
    chk("locked", 32'ha5, 32'(rx_buf)); // discard
    rdc("full", `OFS_STATUS, 1 << `ST_FULL); // long
    pulse(EMP);
    @(posedge clk);
    chk("hold", 1, 32'(tx_hold)); // empty
    wr(`OFS_STATUS, 32'h18);
    @(posedge clk);
    chk("release", 0, 32'(tx_hold)); // refill
    clr;
    wr(`OFS_CTRL_ONE, 0);
  endtask
  task automatic t_frame;
    rx_rsp <= 1'b1;
    hold <= 1'b1;
    pulse(STP);
    hold <= 1'b0;
    pulse(RXD);
    rdc("framing", `OFS_ERROR, 1 << `ER_FRAMING); // stop
    rdc("rx blocked", `OFS_STATUS, 0); // framing
    pulse(FE);
    pulse(RXD);
    rdc("rx done", `OFS_STATUS, 1 << `ST_RX_DONE); // done
    rx_rsp <= 1'b0;
    clr;
    hold <= 1'b1;
    pulse(BS);
    rdc("no bit err", `OFS_ERROR, 0); // phase
    tx_rsp <= 1'b1;
    pulse(BS);
    hold <= 1'b0;
    pulse(TXD);
    rdc("bit error", `OFS_ERROR, 1 << `ER_BIT); // readback
    rdc("tx blocked", `OFS_STATUS, 0); // suppress
    wr(`OFS_CTRL_ONE, 1 << `CR_IDLE_ON_BIT_ERROR);
    pulse(TXD);
    rdc("tx idle_on_bit_error", `OFS_STATUS, 1 << `ST_TX_DONE); // idle_on_bit_error
    tx_rsp <= 1'b0;
    pulse(FE);
    clr;
    // Header phases: master checks read-back, slave checks stop bit
    {tx_hdr, rx_hdr, master, hold} <= 4'hf;
    tx_lvl <= 1'b0;
    pulse(BS);
    pulse(STP);
    rdc("master header", `OFS_ERROR, 0); // match
    tx_lvl <= 1'b1;
    pulse(BS);
    master <= 1'b0;
    pulse(STP);
    {tx_hdr, rx_hdr, hold} <= 3'h0;
    rdc("header phase", `OFS_ERROR, 32'h108); // mismatch
    pulse(FE);
    clr;
    wr(`OFS_CTRL_ONE, 0);
  endtask
  task automatic t_hdr;
    // Filter enable, active, match, tx match, bypass, expected flag
    logic [5:0] cs [6] = '{6'b000001, 6'b111010, 6'b100011,
                           6'b100000, 6'b110011, 6'b111101};
    for (int i = 0; i < 6; i++) begin
      {f_en, f_act, f_mat, f_tx} <= cs[i][5:2];
      wr(`OFS_CTRL_ONE, 32'(cs[i][1]) << `CR_BYPASS);
      pulse(HDR);
      rdc("header", `OFS_STATUS, 32'(cs[i][0])); // filter
      pulse(FE);
      rdc("header end", `OFS_STATUS, 0); // frame
    end
    {f_en, f_act, f_mat, f_tx} <= 4'h0;
    wr(`OFS_CTRL_ONE, 0);
  endtask
  task automatic t_stuck;
    hold <= 1'b1;
    ticks(100);
    rdc("stuck 100", `OFS_ERROR, 0); // count
    ticks(1);
    rdc("stuck 101", `OFS_ERROR, 1 << `ER_STUCK); // count
    hold <= 1'b0;
    rdc("stuck kept", `OFS_ERROR, 1 << `ER_STUCK); // hold
    clr;
  endtask
  task automatic t_cmp;
    wr(`OFS_COMPARE, 32'h2211);
    wr(`OFS_TIMEOUT_CTRL, 1 << `TC_IDLE_ON_TIMEOUT);
    t_run <= 1'b1;
    t_cnt <= 8'h12;
    rdc("no match", `OFS_ERROR, 0); // value
    t_cnt <= 8'h11;
    @(posedge clk);
    t_cnt <= 8'h12;
    @(posedge clk);
    chk("go idle", 1, 32'(go_idle)); // idle
    clr;
    t_cnt <= 8'h22;
    @(posedge clk);
    t_cnt <= 8'h12;
    init_pulse;
    rdc("init kept", `OFS_ERROR, 1 << `ER_COMPARE); // mode
    wr(`OFS_TIMEOUT_CTRL, 1 << `TC_TIMEOUT_MODE);
    @(posedge clk);
    chk("idle off", 0, 32'(go_idle)); // gate
    init_pulse;
    rdc("init clr", `OFS_ERROR, 0); // mode
    t_run <= 1'b0;
    wr(`OFS_TIMEOUT_CTRL, 0);
  endtask
  task automatic t_herr;
    wr(`OFS_IRQ_EN, 1 << `IE_HEADER_ERR);
    rx_id <= 8'h80;
    pulse(IDV);
    rdc("good parity", `OFS_ERROR, 0); // parity
    rx_id <= 8'h00;
    pulse(IDV);
    @(posedge clk);
    chk("header irq", 1, 32'(hdr_irq)); // irq
    rdc("bad parity", `OFS_ERROR, 1 << `ER_ID_PARITY); // parity
    clr;
    pulse(SYN);
    pulse(DLM);
    rdc("sync delim", `OFS_ERROR, 32'h60); // flags
    wr(`OFS_IRQ_EN, 0);
    @(posedge clk);
    chk("irq masked", 0, 32'(hdr_irq)); // mask
    clr;
    rx_chk <= 8'h55;
    calc_chk <= 8'h56;
    wr(`OFS_CTRL_ONE, 1 << `CR_CCD);
    pulse(CHK);
    wr(`OFS_CTRL_ONE, 1 << `CR_CFD);
    pulse(CHK);
    rdc("chk off", `OFS_ERROR, 0); // disabled
    wr(`OFS_CTRL_ONE, 0);
    pulse(CHK);
    pulse(NOI);
    rdc("chk noise", `OFS_ERROR, 32'h81); // set
    @(posedge clk);
    wr_en <= 1'b1;
    addr <= `OFS_ERROR;
    wdata <= 1 << `ER_NOISE;
    ev <= 14'h1 << NOI;
    @(posedge clk);
    wr_en <= 1'b0;
    ev <= 14'h0;
    rdc("set wins", `OFS_ERROR, 32'h81); // priority
    clr;
    rdc("reserved", `OFS_ERROR, 0); // zero
  endtask
  task automatic end_sim;
    if (bad_count == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    rdc("status rst", `OFS_STATUS, 0);
    wr(8'h18, 32'hffffffff);
    rdc("unmapped", 8'h18, 0);
    t_wake;
    t_buf;
    t_frame;
    t_hdr;
    t_stuck;
    t_cmp;
    t_herr;
    end_sim;
  end
  initial begin
    #100000;
    bad_count++;
    end_sim;
  end
endmodule
